// ### rtl/sdt_pkg.sv
// Package for the split dual byte timer control block.
// Assumes a 32-bit APB slave where each byte register takes one aligned word.

package sdt_pkg;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [5:0] SDT_IDX_PRESCALE_EN  = 6'h00;
  localparam logic [5:0] SDT_IDX_OUT_ENABLE   = 6'h01;
  localparam logic [5:0] SDT_IDX_OUT_LEVEL    = 6'h02;
  localparam logic [5:0] SDT_IDX_SPLIT_SELECT = 6'h03;
  localparam logic [5:0] SDT_IDX_CMD_CLEAR    = 6'h04;
  localparam logic [5:0] SDT_IDX_CMD_SET      = 6'h05;
  localparam logic [5:0] SDT_IDX_INT_ENABLE   = 6'h0a;
  localparam logic [5:0] SDT_IDX_INT_FLAG     = 6'h0b;
  localparam logic [5:0] SDT_IDX_LOW_CNT      = 6'h20;
  localparam logic [5:0] SDT_IDX_HIGH_CNT     = 6'h21;
  localparam logic [5:0] SDT_IDX_LOW_PER      = 6'h26;
  localparam logic [5:0] SDT_IDX_HIGH_PER     = 6'h27;
  localparam logic [5:0] SDT_IDX_CMP_BASE     = 6'h28;
  localparam logic [5:0] SDT_IDX_CMP_LAST     = 6'h2d;

  // ----------------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------------
  localparam int unsigned SDT_ENABLE_BIT    = 0;
  localparam int unsigned SDT_PRESCALE_LSB  = 1;
  localparam int unsigned SDT_SPLIT_BIT     = 0;
  localparam int unsigned SDT_CMD_LSB       = 2;
  localparam int unsigned SDT_TARGET_LSB    = 0;
  localparam int unsigned SDT_HIGH_OUT_LSB  = 4;
  localparam int unsigned SDT_LOW_UNF_BIT   = 0;
  localparam int unsigned SDT_HIGH_UNF_BIT  = 1;
  localparam int unsigned SDT_LOW_CMP_LSB   = 4;
  localparam logic [7:0]  SDT_OUT_MASK      = 8'h77;
  localparam logic [7:0]  SDT_INT_MASK      = 8'h73;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] SDT_REG_RST = 8'h00;
  localparam logic [7:0] SDT_PER_RST = 8'hff;

  // ----------------------------------------------------------------------
  // Commands and targets
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SDT_CMD_NONE       = 2'b00,
    SDT_CMD_RESERVED   = 2'b01,
    SDT_CMD_RESTART    = 2'b10,
    SDT_CMD_HARD_RESET = 2'b11
  } sdt_cmd_type;

  localparam logic [1:0] SDT_TARGET_BOTH = 2'b11;

  // ----------------------------------------------------------------------
  // Prescaler terminal counts, divide by 1,2,4,8,16,64,256,1024
  // ----------------------------------------------------------------------
  localparam int unsigned SDT_PRESC_W = 10;
  localparam logic [9:0] SDT_DIV_TERM [8] = '{10'h000, 10'h001, 10'h003, 10'h007,
                                              10'h00f, 10'h03f, 10'h0ff, 10'h3ff};

endpackage

// ### rtl/sdt_prescaler.sv
// Count clock prescaler for the split dual byte timer.
// Assumes run and clear are synchronous to pclk; tick is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none

module sdt_prescaler
  import sdt_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       run,
  input  wire logic       clear,
  input  wire logic [2:0] sel,
  // Count clock pulse
  output logic            tick
);

  typedef struct packed {
    logic [SDT_PRESC_W-1:0] cnt;
  } sdt_presc_state_type;

  sdt_presc_state_type s_r;
  sdt_presc_state_type s_nxt;

  // ----------------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------------
  assign tick = run && !clear && (s_r.cnt == SDT_DIV_TERM[sel]);

  always_comb
  begin
    s_nxt = s_r;
    // Restart realigns the divider so the first period is whole
    if (!run || clear || tick)
      s_nxt.cnt = '0;
    else
      s_nxt.cnt = s_r.cnt + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_div64_spacing;
    @(posedge pclk) disable iff (!presetn)
    (tick && sel == 3'h5 && $stable(sel)) |=> !tick [*8];
  endproperty
  a_div64_spacing: assert property (p_div64_spacing) else $error("divide by 64 ticked too early");

endmodule
`default_nettype wire

// ### rtl/sdt_split_timer.sv
// Split dual byte timer control: two 8-bit down counters, commands, flags, waveforms.
// Assumes an APB master on pclk; registers sit at four times their index.
//
// Functional notes
// - Count clock is pclk divided by 1,2,4,8,16,64,256,1024 from prescale bits 3:1.
// - Timer counts only while the enable bit 0 is one.
// - Compare output enable bits hand the waveform pins to the timer.
// - While disabled the output level bits set each waveform output whose output enable bit is one.
// - Split select bit must be one for the two 8-bit counters to count at all.
// - Command 2 restarts, 3 hard resets, hard reset ignored while enabled.
// - Command field always reads as zero in set and clear registers.
// - Commands apply only when target field selects both counters.
// - Writing one to clear register clears just that bit.
// - Writing one to set register sets just that bit.
// - Interrupt enable bits 6:4 enable low byte compare interrupts.
// - Enable bit 1 for high underflow, bit 0 for low underflow.
// - Low compare flag sets on a count tick where low counter equals that channel compare.
// - Compare flags clear only by software writing one or by the hard reset command.
// - High underflow flag bit 1 sets at bottom, sticks until cleared.
// - Low underflow flag bit 0 sets at bottom, sticks until cleared.
// - Software counter write beats a count, clear or reload that cycle.
// - High compare values compared on each count tick for waveform matches.
`timescale 1ns/1ps
`default_nettype none

module sdt_split_timer
#(
  parameter int unsigned NUM_CH = 3
)
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Waveform pins, index 0..2 low byte, 3..5 high byte
  output logic [5:0]       waveform_output_n,
  output logic [5:0]       waveform_override,
  // Interrupt request
  output logic             irq
);

  import sdt_pkg::*;

  // ----------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------
  if (NUM_CH < 1 || NUM_CH > 3)
  begin : g_bad_ch
    $error("NUM_CH must lie between 1 and 3");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                  enable;
    logic [2:0]            count_clock_prescale;
    logic [7:0]            out_enable;
    logic [7:0]            out_level;
    logic                  dual_byte_counter_select;
    logic [1:0]            command_target_select;
    logic [7:0]            int_enable;
    logic [7:0]            int_flags;
    logic [1:0][7:0]       cnt;
    logic [1:0][7:0]       per;
    logic [1:0][2:0][7:0]  cmp;
    logic [1:0][2:0]       wg;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic [5:0]            wave_out;
    logic [5:0]            wave_oe;
    logic                  irq;
  } sdt_state_type;

  sdt_state_type s_r;
  sdt_state_type s_nxt;
  sdt_state_type rst_val;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic logic sdt_mapped(input logic [5:0] idx);
    logic hit;
    hit = 1'b0;
    unique case (idx)
      SDT_IDX_PRESCALE_EN, SDT_IDX_OUT_ENABLE, SDT_IDX_OUT_LEVEL, SDT_IDX_SPLIT_SELECT,
      SDT_IDX_CMD_CLEAR, SDT_IDX_CMD_SET, SDT_IDX_INT_ENABLE, SDT_IDX_INT_FLAG,
      SDT_IDX_LOW_CNT, SDT_IDX_HIGH_CNT, SDT_IDX_LOW_PER, SDT_IDX_HIGH_PER:
        hit = 1'b1;
      default:
        hit = (idx >= SDT_IDX_CMP_BASE) && (idx <= SDT_IDX_CMP_LAST);
    endcase
    return hit;
  endfunction

  logic [5:0] idx;
  logic       addr_ok;
  logic       setup;
  logic       wr_acc;
  logic [7:0] wbyte;
  logic [5:0] cmp_off;
  logic       cmp_sel;
  logic [1:0] cmp_ch;

  assign idx     = paddr[7:2];
  assign addr_ok = (paddr[1:0] == 2'b00) && sdt_mapped(idx);
  assign setup   = psel && !penable;
  assign wr_acc  = psel && penable && s_r.pready && pwrite && addr_ok;
  assign wbyte   = pwdata[7:0];
  assign cmp_off = idx - SDT_IDX_CMP_BASE;
  assign cmp_sel = cmp_off[0];
  assign cmp_ch  = cmp_off[2:1];

  // ----------------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------------
  logic        wr_set;
  logic        wr_clr;
  logic [1:0]  target_nxt;
  sdt_cmd_type cmd;
  logic        do_restart;
  logic        do_hard_reset;
  logic        run;
  logic        tick;

  assign wr_set        = wr_acc && idx == SDT_IDX_CMD_SET;
  assign wr_clr        = wr_acc && idx == SDT_IDX_CMD_CLEAR;
  assign target_nxt    = s_r.command_target_select | wbyte[SDT_TARGET_LSB +: 2];
  assign cmd           = sdt_cmd_type'(wbyte[SDT_CMD_LSB +: 2]);
  // Reserved target codes select nothing, so only both counters act
  assign do_restart    = wr_set && cmd == SDT_CMD_RESTART && target_nxt == SDT_TARGET_BOTH;
  assign do_hard_reset = wr_set && cmd == SDT_CMD_HARD_RESET && target_nxt == SDT_TARGET_BOTH
                         && !s_r.enable;
  assign run           = s_r.enable && s_r.dual_byte_counter_select;

  sdt_prescaler u_prescaler (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (run),
    .clear   (do_restart),
    .sel     (s_r.count_clock_prescale),
    .tick    (tick)
  );

  // ----------------------------------------------------------------------
  // Reset image for the hard reset command, same values that presetn loads
  // ----------------------------------------------------------------------
  always_comb
  begin
    rst_val     = '0;
    rst_val.per = {SDT_PER_RST, SDT_PER_RST};
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  function automatic logic [7:0] sdt_read(input sdt_state_type s, input logic [5:0] i,
                                          input logic sel_hi, input logic [1:0] ch);
    logic [7:0] d;
    d = 8'h00;
    unique case (i)
      SDT_IDX_PRESCALE_EN:  d = {4'h0, s.count_clock_prescale, s.enable};
      SDT_IDX_OUT_ENABLE:   d = s.out_enable;
      SDT_IDX_OUT_LEVEL:    d = s.out_level;
      SDT_IDX_SPLIT_SELECT: d = {7'h00, s.dual_byte_counter_select};
      SDT_IDX_CMD_CLEAR,
      SDT_IDX_CMD_SET:      d = {6'h00, s.command_target_select};
      SDT_IDX_INT_ENABLE:   d = s.int_enable;
      SDT_IDX_INT_FLAG:     d = s.int_flags;
      SDT_IDX_LOW_CNT:      d = s.cnt[0];
      SDT_IDX_HIGH_CNT:     d = s.cnt[1];
      SDT_IDX_LOW_PER:      d = s.per[0];
      SDT_IDX_HIGH_PER:     d = s.per[1];
      default:
        if (i >= SDT_IDX_CMP_BASE && i <= SDT_IDX_CMP_LAST && ch < 2'(NUM_CH))
          d = s.cmp[sel_hi][ch];
    endcase
    return d;
  endfunction

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  logic [7:0] flag_set;
  logic [7:0] flag_clr;

  always_comb
  begin
    s_nxt    = s_r;
    flag_set = 8'h00;
    flag_clr = 8'h00;

    // APB answer: one access cycle, never a wait state
    s_nxt.pready  = setup;
    s_nxt.pslverr = setup && !addr_ok;
    if (setup)
      s_nxt.prdata = (addr_ok && !pwrite) ? {24'h00_0000, sdt_read(s_r, idx, cmp_sel, cmp_ch)} : 32'h0000_0000;

    // Counting
    for (int b = 0; b < 2; b++)
    begin
      if (tick)
      begin
        for (int c = 0; c < NUM_CH; c++)
        begin
          if (s_r.cnt[b] == s_r.cmp[b][c])
          begin
            s_nxt.wg[b][c] = 1'b1;
            if (b == 0)
              flag_set[SDT_LOW_CMP_LSB + c] = 1'b1;
          end
        end
        if (s_r.cnt[b] == 8'h00)
        begin
          s_nxt.cnt[b] = s_r.per[b];
          s_nxt.wg[b]  = 3'b000;
          flag_set[b == 0 ? SDT_LOW_UNF_BIT : SDT_HIGH_UNF_BIT] = 1'b1;
        end
        else
          s_nxt.cnt[b] = s_r.cnt[b] - 8'h01;
      end
      if (do_restart)
      begin
        s_nxt.cnt[b] = s_r.per[b];
        s_nxt.wg[b]  = 3'b000;
      end
    end

    // Register writes, after counting so they win
    if (wr_acc)
    begin
      unique case (idx)
        SDT_IDX_PRESCALE_EN:
        begin
          s_nxt.enable               = wbyte[SDT_ENABLE_BIT];
          s_nxt.count_clock_prescale = wbyte[SDT_PRESCALE_LSB +: 3];
        end
        SDT_IDX_OUT_ENABLE:   s_nxt.out_enable = wbyte & SDT_OUT_MASK;
        SDT_IDX_OUT_LEVEL:    s_nxt.out_level = wbyte & SDT_OUT_MASK;
        SDT_IDX_SPLIT_SELECT: s_nxt.dual_byte_counter_select = wbyte[SDT_SPLIT_BIT];
        SDT_IDX_CMD_CLEAR:
          s_nxt.command_target_select = s_r.command_target_select & ~wbyte[SDT_TARGET_LSB +: 2];
        SDT_IDX_CMD_SET:      s_nxt.command_target_select = target_nxt;
        SDT_IDX_INT_ENABLE:   s_nxt.int_enable = wbyte & SDT_INT_MASK;
        SDT_IDX_INT_FLAG:     flag_clr = wbyte & SDT_INT_MASK;
        SDT_IDX_LOW_CNT:      s_nxt.cnt[0] = wbyte;
        SDT_IDX_HIGH_CNT:     s_nxt.cnt[1] = wbyte;
        SDT_IDX_LOW_PER:      s_nxt.per[0] = wbyte;
        SDT_IDX_HIGH_PER:     s_nxt.per[1] = wbyte;
        default:
          if (cmp_ch < 2'(NUM_CH))
            s_nxt.cmp[cmp_sel][cmp_ch] = wbyte;
      endcase
    end

    // A flag event in the clearing cycle survives
    s_nxt.int_flags = (s_r.int_flags & ~flag_clr) | flag_set;

    if (do_hard_reset)
    begin
      s_nxt         = rst_val;
      s_nxt.pready  = 1'b0;
      s_nxt.prdata  = s_r.prdata;
    end

    // Stopped timer shows the programmed levels
    if (!s_nxt.enable)
      for (int b = 0; b < 2; b++)
        s_nxt.wg[b] = s_nxt.out_level[b * SDT_HIGH_OUT_LSB +: 3];

    s_nxt.wave_oe  = {s_nxt.out_enable[SDT_HIGH_OUT_LSB +: 3], s_nxt.out_enable[2:0]};
    s_nxt.wave_out = {s_nxt.wg[1], s_nxt.wg[0]} & s_nxt.wave_oe;
    s_nxt.irq      = |(s_nxt.int_flags & s_nxt.int_enable);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r     <= '0;
      s_r.per <= {SDT_PER_RST, SDT_PER_RST};
    end
    else
      s_r <= s_nxt;
  end

  assign prdata            = s_r.prdata;
  assign pready            = s_r.pready;
  assign pslverr           = s_r.pslverr;
  assign waveform_output_n = s_r.wave_out;
  assign waveform_override = s_r.wave_oe;
  assign irq               = s_r.irq;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic cnt_touch;
  assign cnt_touch = do_restart || do_hard_reset || (wr_acc && (idx == SDT_IDX_LOW_CNT));

  sequence s_low_bottom;
    tick && s_r.cnt[0] == 8'h00 && !cnt_touch;
  endsequence
  property p_count_write_wins;
    (wr_acc && idx == SDT_IDX_LOW_CNT) |=> s_r.cnt[0] == $past(pwdata[7:0]);
  endproperty
  a_count_write_wins: assert property (p_count_write_wins) else $error("counter write lost");
  property p_stopped_holds;
    (!run && !cnt_touch) |=> $stable(s_r.cnt[0]);
  endproperty
  a_stopped_holds: assert property (p_stopped_holds) else $error("counter moved while stopped");
  property p_low_underflow;
    s_low_bottom |=> s_r.int_flags[SDT_LOW_UNF_BIT] && s_r.cnt[0] == $past(s_r.per[0]);
  endproperty
  a_low_underflow: assert property (p_low_underflow) else $error("low underflow missed");
  property p_cmp_flag;
    (tick && s_r.cnt[0] == s_r.cmp[0][0] && !do_hard_reset) |=> s_r.int_flags[SDT_LOW_CMP_LSB];
  endproperty
  a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag not set");
  property p_flag_sticky;
    (s_r.int_flags[SDT_LOW_CMP_LSB] && !do_hard_reset
     && !(wr_acc && idx == SDT_IDX_INT_FLAG && wbyte[SDT_LOW_CMP_LSB])) |=> s_r.int_flags[SDT_LOW_CMP_LSB];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("compare flag cleared by itself");
  property p_cmd_reads_zero;
    (psel && penable && pready && !pwrite && (idx == SDT_IDX_CMD_SET || idx == SDT_IDX_CMD_CLEAR))
      |-> prdata[3:2] == 2'b00;
  endproperty
  a_cmd_reads_zero: assert property (p_cmd_reads_zero) else $error("command field read nonzero");
  property p_hard_reset_ignored;
    (wr_set && cmd == SDT_CMD_HARD_RESET && s_r.enable) |=> s_r.enable;
  endproperty
  a_hard_reset_ignored: assert property (p_hard_reset_ignored) else $error("hard reset while enabled");
  property p_set_clear_target;
    ((wr_set || wr_clr) && !do_hard_reset) |=> s_r.command_target_select == ($past(wr_set)
      ? ($past(s_r.command_target_select) | $past(pwdata[1:0]))
      : ($past(s_r.command_target_select) & ~$past(pwdata[1:0])));
  endproperty
  a_set_clear_target: assert property (p_set_clear_target) else $error("target bits wrong");
  property p_stopped_level;
    !s_r.enable |-> waveform_output_n == ({s_r.out_level[6:4], s_r.out_level[2:0]} & waveform_override);
  endproperty
  a_stopped_level: assert property (p_stopped_level) else $error("stopped output level wrong");
  property p_irq_tracks;
    irq == |(s_r.int_flags & s_r.int_enable);
  endproperty
  a_irq_tracks: assert property (p_irq_tracks) else $error("interrupt request mismatch");
  property p_high_cmp_wave;
    (tick && !wr_acc && s_r.cnt[1] == s_r.cmp[1][0] && s_r.cnt[1] != 8'h00) |=> s_r.wg[1][0];
  endproperty
  a_high_cmp_wave: assert property (p_high_cmp_wave) else $error("high compare wave not set");
endmodule
`default_nettype wire

// ### verif/sdt_split_timer_test.sv
// Self-checking bench for the split dual byte timer control block.
// Assumes the APB slave answers within a few cycles and registers sit at four times their index.
`timescale 1ns/1ps
`default_nettype none

module split_dual_byte_timer_control_test;
  import sdt_pkg::*;

  // --------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  waveform_output_n;
  logic [5:0]  waveform_override;
  logic        irq;
  int          mismatches;
  int          checks;
  logic [31:0] rd;
  logic        err;
  logic        seen_hi;

  typedef struct {logic [5:0] idx; logic [7:0] wd; logic [7:0] exp;} sdt_row_type;
  sdt_row_type rows [10];
  logic [5:0]  rst_idx [13];

  sdt_split_timer u_sdt_split_timer (
    .pclk              (pclk),
    .presetn           (presetn),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .prdata            (prdata),
    .pready            (pready),
    .pslverr           (pslverr),
    .waveform_output_n (waveform_output_n),
    .waveform_override (waveform_override),
    .irq               (irq)
  );

  always #10 pclk = ~pclk;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      mismatches++;
      $display("BAD pready timeout");
      close_out();
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [5:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(nm, rd, {24'h00_0000, exp});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial
  begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
    mismatches = 0; checks = 0;
    rows[0] = '{SDT_IDX_OUT_ENABLE,   8'hff, 8'h77};
    rows[1] = '{SDT_IDX_OUT_LEVEL,    8'h55, 8'h55};
    rows[2] = '{SDT_IDX_SPLIT_SELECT, 8'h01, 8'h01};
    rows[3] = '{SDT_IDX_INT_ENABLE,   8'hff, 8'h73};
    rows[4] = '{SDT_IDX_CMD_SET,      8'h0b, 8'h03};
    rows[5] = '{SDT_IDX_CMD_CLEAR,    8'h01, 8'h02};
    rows[6] = '{SDT_IDX_CMD_SET,      8'h00, 8'h02};
    rows[7] = '{SDT_IDX_LOW_PER,      8'h03, 8'h03};
    rows[8] = '{SDT_IDX_HIGH_PER,     8'h05, 8'h05};
    rows[9] = '{SDT_IDX_CMP_BASE,     8'h02, 8'h02};
    rst_idx = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h0a, 6'h0b, 6'h20, 6'h21, 6'h28, 6'h26, 6'h27};
    idle(12);
    presetn <= 1'b1;
    // Period registers reset to all ones, the rest to zero
    foreach (rst_idx[i])
      rd_chk("reset value", rst_idx[i], (i > 10) ? SDT_PER_RST : SDT_REG_RST);
    chk("irq after reset", {31'h0, irq}, 32'h0000_0000);
    $display("done: reset values");

    foreach (rows[i])
    begin
      apb(1'b1, rows[i].idx, rows[i].wd);
      rd_chk("table readback", rows[i].idx, rows[i].exp);
    end
    chk("override", {26'h0, waveform_override}, 32'h0000_003f);
    chk("level out", {26'h0, waveform_output_n}, 32'h0000_002d);
    $display("done: register table");

    // Unmapped index refused, write ignored
    apb(1'b0, 6'h06, 8'h00);
    chk("unmapped err", {31'h0, err}, 32'h0000_0001);
    chk("unmapped data", rd, 32'h0000_0000);
    apb(1'b1, 6'h0c, 8'hff);
    chk("unmapped wr err", {31'h0, err}, 32'h0000_0001);
    $display("done: unmapped");

    // Low counter from 2 at divide by 1: compares 2,0,0 and low underflow
    apb(1'b1, SDT_IDX_LOW_CNT, 8'h02);
    apb(1'b1, SDT_IDX_PRESCALE_EN, 8'h01);
    idle(10);
    rd_chk("flags running", SDT_IDX_INT_FLAG, 8'h71);
    chk("irq set", {31'h0, irq}, 32'h0000_0001);
    apb(1'b1, SDT_IDX_PRESCALE_EN, 8'h00);
    idle(20);
    rd_chk("flags sticky", SDT_IDX_INT_FLAG, 8'h71);
    apb(1'b1, SDT_IDX_INT_FLAG, 8'h71);
    rd_chk("flags cleared", SDT_IDX_INT_FLAG, 8'h00);
    idle(1);
    chk("irq clear", {31'h0, irq}, 32'h0000_0000);
    $display("done: count and flags");

    // High counter: compare 3 raises its wave bit, underflow once the restart value runs out
    apb(1'b1, SDT_IDX_INT_ENABLE, 8'h02);
    apb(1'b1, SDT_IDX_OUT_LEVEL, 8'h05);
    apb(1'b1, SDT_IDX_CMP_BASE + 6'h01, 8'h03);
    rd_chk("high cmp", SDT_IDX_CMP_BASE + 6'h01, 8'h03);
    apb(1'b1, SDT_IDX_PRESCALE_EN, 8'h01);
    seen_hi = 1'b0;
    repeat (300)
    begin
      @(posedge pclk);
      seen_hi = seen_hi | waveform_output_n[3];
    end
    chk("high wave", {31'h0, seen_hi}, 32'h0000_0001);
    apb(1'b1, SDT_IDX_LOW_CNT, 8'h02);
    apb(1'b1, SDT_IDX_PRESCALE_EN, 8'h00);
    apb(1'b0, SDT_IDX_INT_FLAG, 8'h00);
    chk("high unf", rd & 32'h0000_0002, 32'h0000_0002);
    chk("irq high", {31'h0, irq}, 32'h0000_0001);
    $display("done: high underflow");

    // Hard reset refused while enabled, honoured when stopped
    apb(1'b1, SDT_IDX_PRESCALE_EN, 8'h01);
    apb(1'b1, SDT_IDX_CMD_SET, 8'h0f);
    rd_chk("hard reset ignored", SDT_IDX_OUT_ENABLE, 8'h77);
    apb(1'b1, SDT_IDX_PRESCALE_EN, 8'h00);
    apb(1'b1, SDT_IDX_CMD_SET, 8'h0f);
    rd_chk("hard reset outen", SDT_IDX_OUT_ENABLE, 8'h00);
    rd_chk("hard reset target", SDT_IDX_CMD_SET, 8'h00);
    rd_chk("hard reset period", SDT_IDX_LOW_PER, SDT_PER_RST);
    $display("done: commands");

    // Divide by 64: two ticks from count 1 take 128 cycles
    apb(1'b1, SDT_IDX_SPLIT_SELECT, 8'h01);
    apb(1'b1, SDT_IDX_LOW_CNT, 8'h01);
    apb(1'b1, SDT_IDX_PRESCALE_EN, 8'h0b);
    idle(30);
    apb(1'b0, SDT_IDX_INT_FLAG, 8'h00);
    chk("div64 early", rd & 32'h0000_0001, 32'h0000_0000);
    idle(140);
    apb(1'b0, SDT_IDX_INT_FLAG, 8'h00);
    chk("div64 late", rd & 32'h0000_0001, 32'h0000_0001);
    $display("done: prescaler");
    close_out();
  end

  // Whole-run guard
  initial
  begin
    #200_000;
    mismatches++;
    $display("BAD run timeout");
    close_out();
  end

endmodule

`default_nettype wire
